/* File: common/ldorc_params.svh */
/*
  Register offsets, field positions, reset values and voltage figures for
  the regulator control block. Assumes inclusion by bare name.
*/
`ifndef LDORC_PARAMS_SVH
`define LDORC_PARAMS_SVH

// Register offsets (word addresses on the plain port)
`define LDORC_ADDR_CTRL   4'h0
`define LDORC_ADDR_VOUT   4'h1
`define LDORC_ADDR_FAULT  4'h2
`define LDORC_ADDR_STAT   4'h3

// Control register fields
`define LDORC_CTRL_ON     0
`define LDORC_CTRL_STBY   1
`define LDORC_CTRL_SLEEP  2
`define LDORC_CTRL_LPWR   3
`define LDORC_CTRL_SCP    4

// Fault register fields
`define LDORC_FLT_IRQ     0
`define LDORC_FLT_MASK    1

// Reset values
`define LDORC_CTRL_RST    5'h00
`define LDORC_VOUT_RST    4'h0

// Output voltage in millivolts: base plus code times step
`define LDORC_VOUT_BASE_MV 12'd1800
`define LDORC_VOUT_STEP_MV 12'd100

`endif

/* File: common/ldorc_pkg.sv */
/*
  Types for the regulator control block. Assumes ldorc_params.svh exists.
*/
package ldorc_pkg;

  typedef enum logic [1:0] {
    LDORC_PS_RUN,
    LDORC_PS_STANDBY,
    LDORC_PS_SLEEP,
    LDORC_PS_RSVD
  } ldorc_pstate_type;

  typedef enum logic [1:0] {
    LDORC_MODE_OFF,
    LDORC_MODE_ON,
    LDORC_MODE_LOWPWR
  } ldorc_mode_type;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } ldorc_bus_req_type;

  typedef struct packed {
    logic reg_on_bit;
    logic reg_on_in_standby;
    logic reg_on_in_sleep;
    logic reg_low_power_sel;
    logic short_circuit_shutdown_en;
  } ldorc_ctrl_type;

endpackage

/* File: rtl/ldorc_mode_dec.sv */
/*
  Combinational operating-mode decoder: enable bits against power state.
  Assumes ctrl is registered by the caller; pstate comes unregistered from the caller's port.
*/
`timescale 1ns/100ps

module ldorc_mode_dec
  import ldorc_pkg::*;
(
  // Inputs
  input  wire ldorc_ctrl_type   ctrl,
  input  wire ldorc_pstate_type pstate,
  // Result
  output ldorc_mode_type        mode
);

  always_comb begin
    mode = LDORC_MODE_OFF;
    if (ctrl.reg_on_bit) begin
      unique case (pstate)
        LDORC_PS_RUN:     mode = LDORC_MODE_ON;  // R2
        LDORC_PS_STANDBY: begin
          if (ctrl.reg_on_in_standby) begin  // R3
            mode = ctrl.reg_low_power_sel ? LDORC_MODE_LOWPWR : LDORC_MODE_ON;
          end
        end
        LDORC_PS_SLEEP:   begin
          if (ctrl.reg_on_in_sleep) begin  // R3
            mode = ctrl.reg_low_power_sel ? LDORC_MODE_LOWPWR : LDORC_MODE_ON;
          end
        end
        // Reserved state code treated as off for safety
        default:          mode = LDORC_MODE_OFF;
      endcase
    end
  end

endmodule

/* File: rtl/ldorc_top.sv */
/*
  Control logic for one 400 mA linear regulator: output voltage code,
  operating mode against chip power state, overcurrent shutdown and a
  latched, maskable fault flag. Assumes one clock, synchronous reset, and
  an overcurrent input that is already synchronous and high while the
  overload lasts.
*/
// Operation
// (R1) Four-bit code sets target voltage: 1.80 V plus 0.10 V per step.
// (R2) Enable bit 0 means off; Run with enable 1 means on.
// (R3) Standby/Sleep need their own bit, else off; low-power bit selects LP.
// (R4) Protection on plus overcurrent clears enable and raises fault flag.
// (R5) Mask bit blocks the fault flag from reaching the interrupt output.
// (R6) Protection enable resets to 0; then overcurrent leaves regulator on.
// (R7) Fault flag is raised on any overload, protection enabled or not.
// (R8) Flag stays latched until software clears it; software re-enables.
`timescale 1ns/100ps
`include "ldorc_params.svh"

module ldorc_top
  import ldorc_pkg::*;
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Register port
  input  wire logic [3:0]       addr,
  input  wire logic [7:0]       wdata,
  input  wire logic             wr,
  input  wire logic             rd,
  output logic [7:0]            rdata,
  // Chip state and analog status
  input  wire ldorc_pstate_type pstate,
  input  wire logic             overcurrent,
  // Regulator controls
  output logic                  reg_enable,
  output logic                  reg_low_power,
  output logic                  reg_current_limit,
  output logic [3:0]            reg_vout_code,
  output logic [11:0]           reg_vout_mv,
  // Interrupt to processor
  output logic                  reg_fault_irq_out
);

  //////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    ldorc_ctrl_type ctrl;
    logic [3:0]     vout;
    logic           fault_irq;
    logic           fault_mask;
    logic [7:0]     rdata;
    logic           en;
    logic           lp;
    logic           climit;
    logic [11:0]    mv;
    logic           irq;
  } ldorc_state_type;

  ldorc_state_type st_r;
  ldorc_state_type st_nxt;
  ldorc_bus_req_type req;
  ldorc_mode_type    mode;

  assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

  // Millivolt target for a code
  function automatic logic [11:0] vout_mv(input logic [3:0] code);
    vout_mv = `LDORC_VOUT_BASE_MV + 12'(code) * `LDORC_VOUT_STEP_MV;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Mode decode

  ldorc_mode_dec u_mode_dec (
    .ctrl   (st_r.ctrl),
    .pstate (pstate),
    .mode   (mode)
  );

  //////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    st_nxt = st_r;
    st_nxt.rdata = 8'h00;
    if (req.wr) begin
      unique case (req.addr)
        `LDORC_ADDR_CTRL: begin
          st_nxt.ctrl.reg_on_bit        = req.wdata[`LDORC_CTRL_ON];
          st_nxt.ctrl.reg_on_in_standby = req.wdata[`LDORC_CTRL_STBY];
          st_nxt.ctrl.reg_on_in_sleep   = req.wdata[`LDORC_CTRL_SLEEP];
          st_nxt.ctrl.reg_low_power_sel = req.wdata[`LDORC_CTRL_LPWR];
          st_nxt.ctrl.short_circuit_shutdown_en =
            req.wdata[`LDORC_CTRL_SCP];
        end
        `LDORC_ADDR_VOUT: st_nxt.vout = req.wdata[3:0];  // R1
        `LDORC_ADDR_FAULT: begin
          // Write one to clear the flag
          if (req.wdata[`LDORC_FLT_IRQ]) begin
            st_nxt.fault_irq = 1'b0;  // R8
          end
          st_nxt.fault_mask = req.wdata[`LDORC_FLT_MASK];
        end
        default: ;
      endcase
    end
    // Overload sets the flag after any clear, so the event is never lost
    if (overcurrent) begin
      st_nxt.fault_irq = 1'b1;  // R7
      if (st_r.ctrl.short_circuit_shutdown_en) begin
        st_nxt.ctrl.reg_on_bit = 1'b0;  // R4
      end
    end
    if (req.rd) begin
      unique case (req.addr)
        `LDORC_ADDR_CTRL:  st_nxt.rdata = {3'h0,
          st_r.ctrl.short_circuit_shutdown_en, st_r.ctrl.reg_low_power_sel,
          st_r.ctrl.reg_on_in_sleep, st_r.ctrl.reg_on_in_standby,
          st_r.ctrl.reg_on_bit};
        `LDORC_ADDR_VOUT:  st_nxt.rdata = {4'h0, st_r.vout};
        `LDORC_ADDR_FAULT: st_nxt.rdata = {6'h00, st_r.fault_mask,
                                           st_r.fault_irq};
        `LDORC_ADDR_STAT:  st_nxt.rdata = {5'h00, st_r.climit, st_r.lp,
                                           st_r.en};
        default:           st_nxt.rdata = 8'h00;
      endcase
    end
    st_nxt.en     = (mode != LDORC_MODE_OFF);  // R2 R3
    st_nxt.lp     = (mode == LDORC_MODE_LOWPWR);  // R3
    // Without shutdown the regulator stays on and limits its current
    st_nxt.climit = overcurrent && (mode != LDORC_MODE_OFF);  // R6
    st_nxt.mv     = vout_mv(st_r.vout);  // R1
    st_nxt.irq    = st_r.fault_irq && !st_r.fault_mask;  // R5
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r      <= '0;
      st_r.ctrl <= ldorc_ctrl_type'(`LDORC_CTRL_RST);  // R6
      st_r.vout <= `LDORC_VOUT_RST;
      st_r.mv   <= `LDORC_VOUT_BASE_MV;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdata             = st_r.rdata;
  assign reg_enable        = st_r.en;
  assign reg_low_power     = st_r.lp;
  assign reg_current_limit = st_r.climit;
  assign reg_vout_code     = st_r.vout;
  assign reg_vout_mv       = st_r.mv;
  assign reg_fault_irq_out = st_r.irq;

  //////////////////////////////////////////////////////////////////////////
  // Checks

  sequence s_ovc_prot;
    overcurrent && st_r.ctrl.short_circuit_shutdown_en;
  endsequence

  sequence s_on_cleared;
    !st_r.ctrl.reg_on_bit ##1 !reg_enable;
  endsequence

  a_vout_mv: assert property (@(posedge clk) disable iff (rst)  // R1
    reg_vout_mv == $past(`LDORC_VOUT_BASE_MV
      + 12'(st_r.vout) * `LDORC_VOUT_STEP_MV))
    else $error("voltage target mismatch");

  a_off_when_dis: assert property (@(posedge clk) disable iff (rst)  // R2
    !st_r.ctrl.reg_on_bit |=> !reg_enable)
    else $error("regulator on while disabled");

  a_run_on: assert property (@(posedge clk) disable iff (rst)  // R2
    st_r.ctrl.reg_on_bit && pstate == LDORC_PS_RUN |=> reg_enable)
    else $error("regulator off in run");

  a_stby_mode: assert property (@(posedge clk) disable iff (rst)  // R3
    st_r.ctrl.reg_on_bit && pstate == LDORC_PS_STANDBY |=>
      reg_enable == $past(st_r.ctrl.reg_on_in_standby) &&
      reg_low_power == ($past(st_r.ctrl.reg_on_in_standby)
                        && $past(st_r.ctrl.reg_low_power_sel)))
    else $error("standby mode wrong");

  a_sleep_mode: assert property (@(posedge clk) disable iff (rst)  // R3
    st_r.ctrl.reg_on_bit && pstate == LDORC_PS_SLEEP |=>
      reg_enable == $past(st_r.ctrl.reg_on_in_sleep))
    else $error("sleep mode wrong");

  a_scp_shut: assert property (@(posedge clk) disable iff (rst)  // R4
    s_ovc_prot |=> st_r.fault_irq ##0 s_on_cleared)
    else $error("no shutdown on overcurrent");

  a_irq_mask: assert property (@(posedge clk) disable iff (rst)  // R5
    st_r.fault_mask |=> !reg_fault_irq_out)
    else $error("masked fault forwarded");

  a_no_scp_keep: assert property (@(posedge clk) disable iff (rst)  // R6
    overcurrent && !st_r.ctrl.short_circuit_shutdown_en &&
      st_r.ctrl.reg_on_bit |=> st_r.ctrl.reg_on_bit)
    else $error("disabled without protection");

  // Unprotected overload must show up as current-limit operation
  a_limit_no_scp: assert property (@(posedge clk) disable iff (rst)  // R6
    overcurrent && !st_r.ctrl.short_circuit_shutdown_en &&
      st_r.ctrl.reg_on_bit && pstate == LDORC_PS_RUN |=>
      reg_current_limit && reg_enable)
    else $error("no current limit without protection");

  a_fault_any: assert property (@(posedge clk) disable iff (rst)  // R7
    overcurrent |=> st_r.fault_irq)
    else $error("overload not flagged");

  a_flag_hold: assert property (@(posedge clk) disable iff (rst)  // R8
    st_r.fault_irq && !(wr && addr == `LDORC_ADDR_FAULT
      && wdata[`LDORC_FLT_IRQ]) |=> st_r.fault_irq)
    else $error("fault flag dropped");

endmodule

/* File: sim/ldorc_load_model.sv */
/*
  Load at the regulator output, giving the overload detect.
  Assumes the bench sets heavy to ask for an overload.
*/
`timescale 1ns/100ps

module ldorc_load_model (
  // Load request and regulator state
  input  wire logic heavy,
  input  wire logic reg_enable,
  // Overload detect
  output logic      overcurrent
);
  // Only a powered output overloads; a shut-down one drops the detect
  assign overcurrent = heavy & reg_enable;
endmodule

/* File: sim/tb_top.sv */
/*
  Self-checking bench for the regulator control block.
  Assumes the block's register map and a one-cycle read latency.
*/
`timescale 1ns/100ps

module tb_top
  import ldorc_pkg::*;
;
  logic             clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
  logic             chk = 1'b0, rd_d = 1'b0, heavy = 1'b0;
  logic [3:0]       addr = 4'h0, code, cur_code = 4'h0;
  logic [7:0]       wdata = 8'h00, rdata;
  ldorc_pstate_type pstate = LDORC_PS_RUN;
  logic             oc, en, lp, cl, irq;
  logic [11:0]      mv, cur_mv = 12'h708;
  logic [7:0]       rq[$];
  logic [19:0]      lq[$];
  logic [31:0]      seed = 32'hf5ba57a3;
  int               fails = 0, n_tests = 0;

  always #10 clk = ~clk;

  ldorc_top dut_u (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .pstate(pstate), .overcurrent(oc),
    .reg_enable(en), .reg_low_power(lp), .reg_current_limit(cl),
    .reg_vout_code(code), .reg_vout_mv(mv), .reg_fault_irq_out(irq));
  ldorc_load_model load_u (.heavy(heavy), .reg_enable(en),
    .overcurrent(oc));

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  task automatic rd_exp(input logic [3:0] a, input logic [7:0] e);
    rq.push_back(e);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
  endtask

  // Snapshot: interrupt, {limit, low power, enable}, code, millivolts
  task automatic lvl_exp(input logic i, input logic [2:0] s);
    lq.push_back({i, s, cur_code, cur_mv});
    @(posedge clk);
    chk <= 1'b1;
    @(posedge clk);
    chk <= 1'b0;
  endtask

  task automatic cmp_rd(input logic [7:0] got, input logic [7:0] e);
    n_tests++;
    if (got !== e) begin
      fails++;
      $display("mismatch t=%0t rdata %h exp %h", $time, got, e);
    end
  endtask

  task automatic cmp_lvl(input logic [19:0] got, input logic [19:0] e);
    n_tests++;
    if (got !== e) begin
      fails++;
      $display("mismatch t=%0t levels %h exp %h", $time, got, e);
    end
  endtask

  task automatic waitn(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Read data stands only in the cycle after the strobe: sample mid-cycle
  always @(posedge clk) begin
    rd_d <= rd;
  end
  always @(negedge clk) begin
    if (rd_d === 1'b1) begin
      cmp_rd(rdata, rq.pop_front());
    end
    if (chk === 1'b1) begin
      cmp_lvl({irq, cl, lp, en, code, mv}, lq.pop_front());
    end
  end

  initial begin
    waitn(20000);
    fails++;
    summarize();
  end

  initial begin
    logic e, l;
    waitn(2);
    rst <= 1'b0;
    rd_exp(4'h0, 8'h00);
    lvl_exp(1'b0, 3'h0);
    $display("reset values done");
    for (int c = 0; c < 16; c++) begin
      wr_reg(4'h1, 8'(c));
      cur_code = 4'(c);
      cur_mv = 12'h708 + 12'h064 * 12'(c);
      waitn(3);
      lvl_exp(1'b0, 3'h0);
    end
    $display("voltage codes done");
    for (int k = 0; k < 32; k++) begin
      seed = lfsr(seed);
      e = seed[0];
      l = 1'b0;
      case (seed[5:4])
        2'h0: l = 1'b0;
        2'h1: {e, l} = {seed[0] & seed[1], seed[3]};
        2'h2: {e, l} = {seed[0] & seed[2], seed[3]};
        default: e = 1'b0;
      endcase
      pstate <= ldorc_pstate_type'(seed[5:4]);
      wr_reg(4'h0, {4'h0, seed[3:0]});
      waitn(3);
      rd_exp(4'h3, {6'h00, l & e, e});
      lvl_exp(1'b0, {1'b0, l & e, e});
    end
    pstate <= LDORC_PS_RUN;
    $display("operating modes done");
    wr_reg(4'h0, 8'h01);
    waitn(3);
    heavy <= 1'b1;
    waitn(3);
    rd_exp(4'h3, 8'h05);
    rd_exp(4'h2, 8'h01);
    lvl_exp(1'b1, 3'h5);
    heavy <= 1'b0;
    waitn(3);
    lvl_exp(1'b1, 3'h1);
    wr_reg(4'h2, 8'h01);
    waitn(3);
    lvl_exp(1'b0, 3'h1);
    $display("overload without shutdown done");
    wr_reg(4'h2, 8'h02);
    heavy <= 1'b1;
    waitn(3);
    heavy <= 1'b0;
    waitn(3);
    lvl_exp(1'b0, 3'h1);
    rd_exp(4'h2, 8'h03);
    wr_reg(4'h2, 8'h00);
    waitn(3);
    lvl_exp(1'b1, 3'h1);
    wr_reg(4'h2, 8'h01);
    $display("fault mask done");
    wr_reg(4'h0, 8'h11);
    waitn(3);
    heavy <= 1'b1;
    waitn(4);
    heavy <= 1'b0;
    rd_exp(4'h0, 8'h10);
    rd_exp(4'h3, 8'h00);
    lvl_exp(1'b1, 3'h0);
    wr_reg(4'h2, 8'h01);
    wr_reg(4'h0, 8'h11);
    waitn(3);
    rd_exp(4'h3, 8'h01);
    lvl_exp(1'b0, 3'h1);
    $display("overload shutdown done");
    wr_reg(4'hf, 8'hff);
    rd_exp(4'hf, 8'h00);
    rd_exp(4'h0, 8'h11);
    waitn(3);
    $display("unmapped access done");
    // Reset in mid-run must drop protection and voltage code again
    rst <= 1'b1;
    waitn(2);
    rst <= 1'b0;
    cur_code = 4'h0;
    cur_mv = 12'h708;
    rd_exp(4'h0, 8'h00);
    lvl_exp(1'b0, 3'h0);
    $display("mid-run reset done");
    summarize();
  end
endmodule
